// >>> rtl/srl_pkg.sv
package srl_pkg;
    // ==========================================
    // register offsets on the control port
    localparam logic [11:0] ADDR_TERM_TUNE_A  = 12'h02ab;
    localparam logic [11:0] ADDR_TERM_CAL_B   = 12'h02ae;
    localparam logic [11:0] ADDR_TERM_TUNE_C  = 12'h02b1;
    localparam logic [11:0] ADDR_TERM_TUNE_D  = 12'h02b2;
    localparam logic [11:0] ADDR_RX_GEN_CTRL  = 12'h0300;
    // paged window for the per-link banks
    localparam logic [11:0] ADDR_PAGE_LO      = 12'h0401;
    localparam logic [11:0] ADDR_PAGE_HI      = 12'h047e;

    // ==========================================
    // reset values
    localparam logic [7:0] RST_TERM_TUNE_A    = 8'h93;
    localparam logic [7:0] RST_TERM_TUNE_C    = 8'hc3;
    localparam logic [7:0] RST_TERM_TUNE_D    = 8'h93;
    localparam logic [7:0] RST_ZERO           = 8'h00;

    // ==========================================
    // field positions and read masks
    localparam int unsigned BIT_CAL_TRIGGER   = 0;
    localparam int unsigned BIT_CSUM_METHOD   = 6;
    localparam int unsigned BIT_LINK_MODE     = 3;
    localparam int unsigned BIT_LINK_PAGE     = 2;
    localparam int unsigned BIT_LINK_EN_LO    = 0;
    localparam logic [7:0] MASK_CAL_B         = 8'h01;
    localparam logic [7:0] MASK_GEN_CTRL      = 8'h4f;

    // ==========================================
    // link enable encodings
    typedef enum logic [1:0] {
        SRL_LINKS_OFF  = 2'b00,
        SRL_LINK0_ONLY = 2'b01,
        SRL_LINK1_ONLY = 2'b10,
        SRL_LINKS_BOTH = 2'b11
    } srl_link_en_t;

    // ==========================================
    // packed link configuration, bytes 0x450..0x45a
    localparam int unsigned CFG_BYTES         = 11;
    localparam int unsigned LID_W             = 5;
    localparam int unsigned CSUM_W            = 8;

    // ==========================================
    // termination calibration sequencer states
    typedef enum logic [1:0] {
        SRL_CAL_IDLE = 2'b01,
        SRL_CAL_RUN  = 2'b10
    } srl_cal_state_t;
endpackage

// >>> rtl/srl_term_cal.sv
// ==========================================
// rising-edge launcher for lane group calibration
module srl_term_cal
    import srl_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // trigger bit from the register file
    input  wire logic        i_trigger,
    // analog calibration handshake
    input  wire logic        i_cal_done,
    output logic             o_cal_start,
    output logic             o_cal_busy
);
    srl_cal_state_t state_r, state_nxt;
    logic           trig_d_r, trig_d_nxt;
    logic           start_r, start_nxt;

    // ==========================================
    // next state: only a 0->1 edge launches
    always_comb begin
        trig_d_nxt = i_trigger;
        state_nxt  = state_r;
        start_nxt  = 1'b0;
        case (state_r)
            SRL_CAL_IDLE: begin
                if (i_trigger && !trig_d_r) begin
                    state_nxt = SRL_CAL_RUN;
                    start_nxt = 1'b1;
                end
            end
            SRL_CAL_RUN: begin
                // edges while running are absorbed, not queued
                if (i_cal_done) begin
                    state_nxt = SRL_CAL_IDLE;
                end
            end
            default: state_nxt = SRL_CAL_IDLE;
        endcase
    end

    // registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r  <= SRL_CAL_IDLE;
            trig_d_r <= 1'b0;
            start_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            trig_d_r <= trig_d_nxt;
            start_r  <= start_nxt;
        end
    end

    assign o_cal_start = start_r;
    assign o_cal_busy  = (state_r == SRL_CAL_RUN);
endmodule

// >>> rtl/srl_checksum.sv
// ==========================================
// per-lane computed link parameter checksum
module srl_checksum
    import srl_pkg::*;
#(
    parameter int unsigned LANES = 8
)
(
    // clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    // method select, 1 = packed byte sum
    input  wire logic                      i_method,
    // packed configuration bytes, byte 0 lowest
    input  wire logic [CFG_BYTES*8-1:0]    i_cfg,
    // per-lane lane identifiers
    input  wire logic [LANES*LID_W-1:0]    i_lane_lid,
    // stored checksums, lane 0 lowest
    output logic [LANES*CSUM_W-1:0]        o_checksum
);
    if (LANES < 1 || LANES > 8) begin : g_chk
        $error("srl_checksum: LANES must be 1..8");
    end

    logic [7:0] b [CFG_BYTES];
    logic [7:0] common_fields;
    logic [7:0] packed_rest;

    // unpack bytes
    for (genvar i = 0; i < CFG_BYTES; i++) begin : g_b
        assign b[i] = i_cfg[i*8 +: 8];
    end

    // field sum without the lane id, all wraps mod 256
    always_comb begin
        common_fields = b[0]
            + {4'h0, b[1][3:0]}
            + {7'h00, b[3][7]} + {3'h0, b[3][4:0]}
            + b[4] + {3'h0, b[5][4:0]}
            + b[6] + {3'h0, b[7][4:0]}
            + {6'h00, b[7][7:6]}
            + {3'h0, b[8][4:0]} + {5'h00, b[8][7:5]}
            + {3'h0, b[9][4:0]} + {5'h00, b[9][7:5]}
            + {3'h0, b[10][4:0]} + {7'h00, b[10][7]};
        packed_rest = b[0] + b[1] + b[3] + b[4] + b[5]
            + b[6] + b[7] + b[8] + b[9] + b[10];
    end

    // one store per lane, lane id patched into byte 2
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LID_W-1:0]  lid;
        logic [CSUM_W-1:0] sum_nxt;
        logic [CSUM_W-1:0] sum_r;
        assign lid = i_lane_lid[l*LID_W +: LID_W];
        always_comb begin
            if (i_method) begin
                sum_nxt = packed_rest
                    + {b[2][7:5], lid};
            end else begin
                sum_nxt = common_fields + {3'h0, lid};
            end
        end
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                sum_r <= RST_ZERO;
            end else begin
                sum_r <= sum_nxt;
            end
        end
        assign o_checksum[l*CSUM_W +: CSUM_W] = sum_r;
    end
endmodule

// >>> rtl/srl_regs.sv
// ==========================================
// serial receiver link control register bank
module srl_regs
    import srl_pkg::*;
#(
    parameter int unsigned LANES = 8
)
(
    // clock and reset
    input  wire logic                           i_clock,
    input  wire logic                           i_rst,
    // register port from the serial control port
    input  wire logic [11:0]                    i_reg_addr,
    input  wire logic                           i_reg_wr,
    input  wire logic [7:0]                     i_reg_wdata,
    input  wire logic                           i_reg_rd,
    output logic [7:0]                          o_reg_rdata,
    output logic                                o_reg_rvalid,
    output logic                                o_reg_hit,
    // paged window decode for the per-link banks
    output logic                                o_page_hit,
    output logic                                o_page_link1,
    // termination tuning to the lane analog
    output logic [7:0]                          o_term_tune_a,
    output logic [7:0]                          o_term_tune_c,
    output logic [7:0]                          o_term_tune_d,
    // lane 2..5 termination calibration
    input  wire logic                           i_cal_done,
    output logic                                o_cal_start,
    output logic                                o_cal_busy,
    // link control
    output logic                                o_link_dual,
    output logic                                o_link0_enable,
    output logic                                o_link1_enable,
    // link configuration for the checksum
    input  wire logic [srl_pkg::CFG_BYTES*8-1:0] i_link_cfg,
    input  wire logic [LANES*srl_pkg::LID_W-1:0] i_lane_lid,
    output logic [LANES*srl_pkg::CSUM_W-1:0]     o_computed_checksum
);
    import srl_pkg::*;

    if (LANES < 1 || LANES > 8) begin : g_chk
        $error("srl_regs: LANES must be 1..8");
    end

    // ==========================================
    // storage
    logic [7:0] tune_a_r, tune_a_nxt;
    logic [7:0] tune_c_r, tune_c_nxt;
    logic [7:0] tune_d_r, tune_d_nxt;
    logic       cal_trig_r, cal_trig_nxt;
    logic       csum_method_r, csum_method_nxt;
    logic       link_mode_r, link_mode_nxt;
    logic       link_page_r, link_page_nxt;
    srl_link_en_t link_en_r, link_en_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;
    logic       hit_r, hit_nxt;
    logic [7:0] ctrl_view;
    logic [7:0] cal_view;
    logic [7:0] rd_mux;
    logic       rd_mapped;

    // ==========================================
    // write decode
    // tuning registers are plain storage; the analog only sees
    // correct termination once software loads its values
    always_comb begin
        tune_a_nxt      = tune_a_r;
        tune_c_nxt      = tune_c_r;
        tune_d_nxt      = tune_d_r;
        cal_trig_nxt    = cal_trig_r;
        csum_method_nxt = csum_method_r;
        link_mode_nxt   = link_mode_r;
        link_page_nxt   = link_page_r;
        link_en_nxt     = link_en_r;
        if (i_reg_wr) begin
            if (i_reg_addr == ADDR_TERM_TUNE_A) begin
                tune_a_nxt = i_reg_wdata;
            end else if (i_reg_addr == ADDR_TERM_TUNE_D) begin
                tune_d_nxt = i_reg_wdata;
            end else if (i_reg_addr == ADDR_TERM_TUNE_C) begin
                tune_c_nxt = i_reg_wdata;
            end else if (i_reg_addr == ADDR_TERM_CAL_B) begin
                // only bit 0 is stored
                cal_trig_nxt = i_reg_wdata[BIT_CAL_TRIGGER];
            end else if (i_reg_addr == ADDR_RX_GEN_CTRL) begin
                // bits 7, 5 and 4 are dropped here
                csum_method_nxt = i_reg_wdata[BIT_CSUM_METHOD];
                link_mode_nxt   = i_reg_wdata[BIT_LINK_MODE];
                link_page_nxt   = i_reg_wdata[BIT_LINK_PAGE];
                link_en_nxt     = srl_link_en_t'(
                    i_reg_wdata[BIT_LINK_EN_LO +: 2]);
            end
        end
    end

    // ==========================================
    // read views with reserved bits held at zero
    always_comb begin
        cal_view = RST_ZERO;
        cal_view[BIT_CAL_TRIGGER] = cal_trig_r;
        ctrl_view = RST_ZERO;
        ctrl_view[BIT_CSUM_METHOD] = csum_method_r;
        ctrl_view[BIT_LINK_MODE]   = link_mode_r;
        ctrl_view[BIT_LINK_PAGE]   = link_page_r;
        ctrl_view[BIT_LINK_EN_LO +: 2] = link_en_r;
    end

    // read decode; unmapped reads return zero
    always_comb begin
        rd_mux    = RST_ZERO;
        rd_mapped = 1'b1;
        if (i_reg_addr == ADDR_TERM_TUNE_A) begin
            rd_mux = tune_a_r;
        end else if (i_reg_addr == ADDR_TERM_CAL_B) begin
            rd_mux = cal_view & MASK_CAL_B;
        end else if (i_reg_addr == ADDR_TERM_TUNE_C) begin
            rd_mux = tune_c_r;
        end else if (i_reg_addr == ADDR_TERM_TUNE_D) begin
            rd_mux = tune_d_r;
        end else if (i_reg_addr == ADDR_RX_GEN_CTRL) begin
            rd_mux = ctrl_view & MASK_GEN_CTRL;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // read answer is registered, one cycle after the strobe
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = i_reg_rd;
        hit_nxt    = hit_r;
        if (i_reg_rd) begin
            rdata_nxt = rd_mux;
            hit_nxt   = rd_mapped;
        end
    end

    // ==========================================
    // state registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tune_a_r      <= RST_TERM_TUNE_A;
            tune_c_r      <= RST_TERM_TUNE_C;
            tune_d_r      <= RST_TERM_TUNE_D;
            cal_trig_r    <= 1'b0;
            csum_method_r <= 1'b0;
            link_mode_r   <= 1'b0;
            link_page_r   <= 1'b0;
            link_en_r     <= SRL_LINKS_OFF;
            rdata_r       <= RST_ZERO;
            rvalid_r      <= 1'b0;
            hit_r         <= 1'b0;
        end else begin
            tune_a_r      <= tune_a_nxt;
            tune_c_r      <= tune_c_nxt;
            tune_d_r      <= tune_d_nxt;
            cal_trig_r    <= cal_trig_nxt;
            csum_method_r <= csum_method_nxt;
            link_mode_r   <= link_mode_nxt;
            link_page_r   <= link_page_nxt;
            link_en_r     <= link_en_nxt;
            rdata_r       <= rdata_nxt;
            rvalid_r      <= rvalid_nxt;
            hit_r         <= hit_nxt;
        end
    end

    // ==========================================
    // link enable decode
    // no interlock against pll lock or phy calibration:
    // software must sequence those before enabling
    always_comb begin
        case (link_en_r)
            SRL_LINKS_OFF: begin
                o_link0_enable = 1'b0;
                o_link1_enable = 1'b0;
            end
            SRL_LINK0_ONLY: begin
                o_link0_enable = 1'b1;
                o_link1_enable = 1'b0;
            end
            SRL_LINK1_ONLY: begin
                o_link0_enable = 1'b0;
                o_link1_enable = 1'b1;
            end
            default: begin
                o_link0_enable = 1'b1;
                o_link1_enable = 1'b1;
            end
        endcase
    end

    // ==========================================
    // paging: bank select only inside the window
    always_comb begin
        o_page_hit   = (i_reg_addr >= ADDR_PAGE_LO) &&
                       (i_reg_addr <= ADDR_PAGE_HI);
        o_page_link1 = o_page_hit && link_page_r;
    end

    // ==========================================
    // calibration launcher for lanes 2..5
    srl_term_cal u_term_cal (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_trigger   (cal_trig_r),
        .i_cal_done  (i_cal_done),
        .o_cal_start (o_cal_start),
        .o_cal_busy  (o_cal_busy)
    );

    // ==========================================
    // computed checksum store
    srl_checksum #(
        .LANES (LANES)
    ) u_checksum (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_method   (csum_method_r),
        .i_cfg      (i_link_cfg),
        .i_lane_lid (i_lane_lid),
        .o_checksum (o_computed_checksum)
    );

    // ==========================================
    // outputs straight from storage
    assign o_term_tune_a = tune_a_r;
    assign o_term_tune_c = tune_c_r;
    assign o_term_tune_d = tune_d_r;
    assign o_link_dual   = link_mode_r;
    assign o_reg_rdata   = rdata_r;
    assign o_reg_rvalid  = rvalid_r;
    assign o_reg_hit     = hit_r;
endmodule

// >>> dv/srl_regs_checker.sv
// ======
// port checker for the link control bank
module srl_regs_checker
    import srl_pkg::*;
(
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_rst,
    // register port
    input wire logic [11:0] i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_wdata,
    // decoded outputs
    input wire logic        o_page_hit,
    input wire logic [7:0]  o_term_tune_a,
    input wire logic        i_cal_done,
    input wire logic        o_cal_start,
    input wire logic        o_cal_busy,
    input wire logic        o_link_dual,
    input wire logic        o_link0_enable,
    input wire logic        o_link1_enable
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic gen_wr;
    // write strobe aimed at the general control byte
    assign gen_wr = i_reg_wr && i_reg_addr == ADDR_RX_GEN_CTRL;

    a_tune_write: assert property (i_reg_wr && i_reg_addr == ADDR_TERM_TUNE_A
        |=> o_term_tune_a == $past(i_reg_wdata))
        else $error("tune byte did not take the write");
    a_cal_launch: assert property ($rose(o_cal_start) |-> $past(i_reg_wr, 2)
        && $past(i_reg_addr, 2) == ADDR_TERM_CAL_B
        && $past(i_reg_wdata[0], 2))
        else $error("calibration launched without a trigger write");
    a_cal_pulse: assert property (o_cal_start |-> o_cal_busy ##1 !o_cal_start)
        else $error("calibration start not a single busy pulse");
    a_busy_end: assert property (o_cal_busy && i_cal_done |=> !o_cal_busy)
        else $error("busy stayed up after finish");
    a_busy_hold: assert property (o_cal_busy && !i_cal_done |=> o_cal_busy)
        else $error("busy dropped before finish");
    a_link_enable: assert property (gen_wr |=> o_link0_enable ==
        $past(i_reg_wdata[0]) && o_link1_enable == $past(i_reg_wdata[1]))
        else $error("link enables do not follow the written code");
    a_link_mode: assert property (gen_wr |=> o_link_dual == $past(i_reg_wdata[3]))
        else $error("link mode does not follow bit 3");
    a_link_hold: assert property (!gen_wr |=>
        $stable({o_link_dual, o_link0_enable, o_link1_enable}))
        else $error("link control moved without a write");
    a_page_window: assert property (o_page_hit == (i_reg_addr >= ADDR_PAGE_LO
        && i_reg_addr <= ADDR_PAGE_HI))
        else $error("paged window decode wrong");

    c_cal: cover property (o_cal_start);
    c_both: cover property (gen_wr && i_reg_wdata[1:0] == 2'h3);
    c_page: cover property (o_page_hit);
endmodule

bind srl_regs srl_regs_checker chk_u (.i_clock, .i_rst, .i_reg_addr,
    .i_reg_wr, .i_reg_wdata, .o_page_hit, .o_term_tune_a, .i_cal_done,
    .o_cal_start, .o_cal_busy, .o_link_dual, .o_link0_enable,
    .o_link1_enable);

// >>> dv/srl_cal_model.sv
// ======
// analog termination calibrator, prompt or slow
module srl_cal_model (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // launch and pace select
    input  wire logic i_start,
    input  wire logic i_slow,
    // finish pulse
    output logic      o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_r;
    // countdown; slow pace leaves room for writes while busy
    always @(posedge i_clock) begin
        o_done <= 1'b0;
        if (i_rst)
            cnt_r <= 6'h00;
        else if (i_start)
            cnt_r <= i_slow ? 6'h14 : 6'h02;
        else if (cnt_r != 6'h00) begin
            cnt_r  <= cnt_r - 6'h01;
            o_done <= cnt_r == 6'h01;
        end
    end
endmodule

// >>> dv/test_srl_regs.sv
module test_srl_regs
    import srl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clock, i_rst, i_reg_wr, i_reg_rd, i_cal_done, cal_slow;
    logic        o_reg_rvalid, o_reg_hit, o_page_hit, o_page_link1;
    logic        o_cal_start, o_cal_busy, o_link_dual;
    logic        o_link0_enable, o_link1_enable;
    logic [11:0] i_reg_addr;
    logic [7:0]  i_reg_wdata, o_reg_rdata;
    logic [7:0]  o_term_tune_a, o_term_tune_c, o_term_tune_d;
    logic [87:0] i_link_cfg;
    logic [39:0] i_lane_lid;
    logic [63:0] o_computed_checksum;
    int          bad_count, compares, starts;

    srl_regs #(.LANES(8)) dut_u (.i_clock, .i_rst, .i_reg_addr, .i_reg_wr,
        .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit,
        .o_page_hit, .o_page_link1, .o_term_tune_a, .o_term_tune_c,
        .o_term_tune_d, .i_cal_done, .o_cal_start, .o_cal_busy,
        .o_link_dual, .o_link0_enable, .o_link1_enable, .i_link_cfg,
        .i_lane_lid, .o_computed_checksum);
    srl_cal_model cal_u (.i_clock, .i_rst, .i_start(o_cal_start),
        .i_slow(cal_slow), .o_done(i_cal_done));

    // ======
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        i_reg_wr    <= 1'b1;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask
    // read answer lands one cycle after the strobe edge
    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic h);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd   <= 1'b1;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1;
        chk(8'(o_reg_rvalid), 8'h01);
        chk(o_reg_rdata, e);
        chk(8'(o_reg_hit), 8'(h));
    endtask
    // bounded wait; the calibrator decides how long busy lasts
    // settle first: a launch shows busy only two edges after its write
    task automatic wait_idle;
        repeat (3) @(posedge i_clock);
        for (int i = 0; i < 40 && o_cal_busy !== 1'b0; i++)
            @(posedge i_clock);
        chk(8'(o_cal_busy), 8'h00);
    endtask

    // ======
    // scenarios
    task automatic t_reset;
        rd(ADDR_TERM_TUNE_A, RST_TERM_TUNE_A, 1'b1);
        rd(ADDR_TERM_CAL_B, RST_ZERO, 1'b1);
        rd(ADDR_TERM_TUNE_C, RST_TERM_TUNE_C, 1'b1);
        rd(ADDR_TERM_TUNE_D, RST_TERM_TUNE_D, 1'b1);
        rd(ADDR_RX_GEN_CTRL, RST_ZERO, 1'b1);
        wr(12'h2ac, 8'h5a);
        rd(12'h2ac, 8'h00, 1'b0);
        $display("reset test done");
    endtask
    task automatic t_tune;
        wr(ADDR_TERM_TUNE_A, 8'h87);
        wr(ADDR_TERM_TUNE_C, 8'hb7);
        wr(ADDR_TERM_TUNE_D, 8'h87);
        rd(ADDR_TERM_TUNE_C, 8'hb7, 1'b1);
        chk(o_term_tune_a, 8'h87);
        chk(o_term_tune_c, 8'hb7);
        chk(o_term_tune_d, 8'h87);
        $display("tuning test done");
    endtask
    // every enable code, with mode and page varied and reserved bits 7, 5 and 4 held set
    task automatic t_ctrl;
        logic [7:0] v;
        for (int n = 0; n < 4; n++) begin
            v = 8'hb0 | 8'(n) | (n[0] ? 8'h08 : 8'h00)
                | (n[1] ? 8'h00 : 8'h04);
            wr(ADDR_RX_GEN_CTRL, v);
            @(posedge i_clock);
            i_reg_addr <= ADDR_PAGE_LO;
            #1;
            chk(8'(o_link0_enable), 8'(v[0]));
            chk(8'(o_link1_enable), 8'(v[1]));
            chk(8'(o_link_dual), 8'(v[3]));
            chk(8'(o_page_link1), 8'(v[2]));
            @(posedge i_clock);
            i_reg_addr <= 12'h47f;
            #1;
            chk(8'(o_page_hit), 8'h00);
            rd(ADDR_RX_GEN_CTRL, v & 8'h4f, 1'b1);
        end
        $display("control test done");
    endtask
    task automatic t_cal;
        @(posedge i_clock);
        cal_slow <= 1'b1;
        wr(ADDR_TERM_CAL_B, 8'hff);
        @(posedge i_clock);
        #1;
        chk(8'(o_cal_start), 8'h01);
        chk(8'(o_cal_busy), 8'h01);
        rd(ADDR_TERM_CAL_B, 8'h01, 1'b1);
        wr(ADDR_TERM_CAL_B, 8'h00);
        wr(ADDR_TERM_CAL_B, 8'h01);
        wait_idle;
        chk(8'(starts), 8'h01);
        cal_slow <= 1'b0;
        wr(ADDR_TERM_CAL_B, 8'h00);
        wr(ADDR_TERM_CAL_B, 8'h01);
        wait_idle;
        chk(8'(starts), 8'h02);
        $display("calibration test done");
    endtask
    // DID 0x12, BID 3, SCR 1, L-1 5; packed sum differs by upper bits
    task automatic t_csum;
        @(posedge i_clock);
        i_link_cfg <= {56'h0, 8'h85, 8'h00, 8'hf3, 8'h12};
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_RX_GEN_CTRL, m[0] ? 8'h40 : 8'h00);
            repeat (2) @(posedge i_clock);
            #1;
            for (int l = 0; l < 8; l++)
                chk(o_computed_checksum[l*8 +: 8],
                    (m[0] ? 8'h8a : 8'h1b) + 8'(l));
        end
        $display("checksum test done");
    endtask

    task automatic summarize;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_cal_start === 1'b1)
            starts++;
    end
    // whole run is roughly a hundred cycles
    initial begin
        #20000;
        bad_count++;
        summarize;
    end
    initial begin
        i_rst       = 1'b1;
        i_reg_wr    = 1'b0;
        i_reg_rd    = 1'b0;
        i_reg_addr  = 12'h000;
        i_reg_wdata = 8'h00;
        cal_slow    = 1'b0;
        i_link_cfg  = '0;
        for (int l = 0; l < 8; l++)
            i_lane_lid[l*5 +: 5] = 5'(l);
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset;
        t_tune;
        t_ctrl;
        t_cal;
        t_csum;
        summarize;
    end
endmodule
